// ---- hw/vram_host_map.svh ----
// register map, timing counts and field positions of the video RAM host controller
// Function
// (RULE1) device: random array plus 512-word serial buffer
// (RULE2) device: block writes four, flash writes row
// (RULE3) device: split transfer loads the idle half
// (RULE4) host refreshes all 512 rows within 8 ms
// (RULE5) cycle type chosen by strobe levels latched
// (RULE6) transfer pin low at row edge: transfer
// (RULE7) device: write enable picks transfer direction
// (RULE8) host: flag high at row edge selects specials
// (RULE9) host: flag high at column edge: block write
// (RULE10) device latches row then column address
// (RULE11) device: row picks line, column start position
// (RULE12) device: write enable low samples bit mask
// (RULE13) device: write enable high means unmasked writes
// (RULE14) device: ignores write enable in plain reads
// (RULE15) device: block write samples column mask
// (RULE16) device: column strobe latches flag, gates pins
// (RULE17) device drives read data under output enable
// (RULE18) device: row strobe active low, high standby
// (RULE19) device: serial data on serial clock rise
// (RULE20) device: serial enable high masks, pointer advances
// (RULE21) device: last transfer sets serial pin direction
// (RULE22) device: half flag shows serial address top
// (RULE23) device: read transfer copies on output-enable rise
// (RULE24) host: read or pseudo transfer before serial access
// (RULE25) device holds write mask whole row cycle
// (RULE26) device: serial pointer increments and wraps
`ifndef VRAM_HOST_MAP_SVH
`define VRAM_HOST_MAP_SVH

// ***************************************************
// register offsets
// ***************************************************
`define REG_CMD      8'h00
`define REG_ROW      8'h04
`define REG_COL      8'h08
`define REG_WDATA    8'h0C
`define REG_MASK     8'h10
`define REG_RDATA    8'h14
`define REG_SERIAL   8'h18
`define REG_CTRL     8'h1C

// ***************************************************
// field positions
// ***************************************************
`define CTRL_SER_MASK 0
`define CTRL_AUTO_REF 1
`define STAT_BUSY     0
`define STAT_SER_BUSY 1
`define STAT_STARTED  2
`define STAT_HOST_DRV 3
`define STAT_HALF     4

// ***************************************************
// timing
// ***************************************************
`define CLK_PERIOD_NS    100
`define REF_WINDOW_NS    8000000
`define REF_ROWS         512
`define REF_INTERVAL_CYC (`REF_WINDOW_NS / `REF_ROWS / `CLK_PERIOD_NS)
`define SC_PULSE_NS      10
`define SC_HALF_CYC      ((`SC_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAS_HOLD_CYC     2'h3
`define SER_WAIT_CYC     3'h1

`endif

// ---- hw/vram_pkg.sv ----
// types shared by the video RAM host controller modules
package vram_pkg;
  typedef enum logic [3:0] {
    OP_READ, OP_WRITE, OP_MASK_WRITE, OP_BLOCK, OP_MASK_BLOCK, OP_FLASH,
    OP_COLOR_WR, OP_COLOR_RD, OP_RD_XFER, OP_SPLIT_RD, OP_WR_XFER,
    OP_SPLIT_WR, OP_PSEUDO, OP_REFRESH
  } op_t;
  typedef enum {ST_IDLE, ST_SETUP, ST_RAS, ST_COL, ST_CAS, ST_DTUP, ST_PRE} arr_state_t;
  typedef enum {S_IDLE, S_LOW, S_HIGH, S_WAIT} ser_state_t;
endpackage

// ---- hw/serial_if.sv ----
// signals between the array sequencer and the serial clock engine
interface serial_if;
  logic       start;
  logic       write;
  logic [3:0] wdata;
  logic       host_drives;
  logic       busy;
  logic [3:0] rdata;
  modport ctrl (output start, write, wdata, host_drives, input busy, rdata);
  modport eng  (input start, write, wdata, host_drives, output busy, rdata);
endinterface

// ---- hw/serial_engine.sv ----
// one serial clock pulse per request, with data out or captured data in
`include "vram_host_map.svh"
module serial_engine import vram_pkg::*; (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // sequencer side
  serial_if.eng           sif,
  // serial pins
  output logic            serial_clock_out,
  input  wire logic [3:0] serial_data_pins_in,
  output logic [3:0]      serial_data_pins_out,
  output logic            serial_data_pins_oe_out
);
  ser_state_t state_r;
  logic [2:0] cnt_r;
  logic       write_r;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] rdata_r;
  logic [3:0] dout_r;
  logic       ck_r;
  logic       oe_r;

  assign sif.busy                = (state_r != S_IDLE);
  assign sif.rdata               = rdata_r;
  assign serial_clock_out        = ck_r;
  assign serial_data_pins_out    = dout_r;
  assign serial_data_pins_oe_out = oe_r;

  always_ff @(posedge clk_in) begin
    sync1_r <= serial_data_pins_in;
    sync2_r <= sync1_r;
  end

  // pin direction follows the last transfer, kept by the sequencer
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= sif.host_drives;
    end
  end

  // ***************************************************
  // clock divider sequence
  // ***************************************************
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_r <= S_IDLE;
      cnt_r   <= 3'h0;
      write_r <= 1'b0;
      ck_r    <= 1'b0;
      dout_r  <= 4'h0;
      rdata_r <= 4'h0;
    end else begin
      case (state_r)
        S_IDLE: if (sif.start) begin
          state_r <= S_LOW;
          cnt_r   <= 3'(`SC_HALF_CYC - 1);
          write_r <= sif.write;
          if (sif.write) begin
            dout_r <= sif.wdata;
          end
        end
        S_LOW: if (cnt_r == 3'h0) begin
          state_r <= S_HIGH;
          ck_r    <= 1'b1;
          cnt_r   <= 3'(`SC_HALF_CYC - 1);
        end else begin
          cnt_r <= cnt_r - 3'h1;
        end
        S_HIGH: if (cnt_r == 3'h0) begin
          state_r <= S_WAIT;
          ck_r    <= 1'b0;
          cnt_r   <= `SER_WAIT_CYC;
        end else begin
          cnt_r <= cnt_r - 3'h1;
        end
        // wait out the pin synchroniser before taking read data
        S_WAIT: if (cnt_r == 3'h0) begin
          state_r <= S_IDLE;
          if (!write_r) begin
            rdata_r <= sync2_r;
          end
        end else begin
          cnt_r <= cnt_r - 3'h1;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule

// ---- hw/vram_host.sv ----
// host controller driving a dual-port video DRAM through its pins
`include "vram_host_map.svh"
module vram_host import vram_pkg::*; (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [31:0]      rdata_out,
  // array port pins
  output logic             ras_n_out,
  output logic             cas_n_out,
  output logic             we_n_out,
  output logic             transfer_or_output_enable_n_out,
  output logic             special_function_flag_out,
  output logic [8:0]       addr_out,
  input  wire logic [3:0]  array_data_pins_in,
  output logic [3:0]       array_data_pins_out,
  output logic             array_data_pins_oe_out,
  // serial port pins
  output logic             serial_port_enable_n_out,
  output logic             serial_clock_out,
  input  wire logic [3:0]  serial_data_pins_in,
  output logic [3:0]       serial_data_pins_out,
  output logic             serial_data_pins_oe_out,
  input  wire logic        split_half_flag_in
);
  arr_state_t state_r;
  op_t        op_r;
  logic [1:0] hold_r;
  logic [8:0] row_r, col_r;
  logic [3:0] wdata_r, mask_r, rdata_r, ad_s1_r, ad_s2_r;
  logic       ser_mask_r, auto_ref_r, started_r, host_drv_r;
  logic       half_s1_r, half_s2_r, ref_pend_r;
  logic [7:0] ref_cnt_r;
  logic [31:0] rdata_r2;
  logic       is_xfer, ras_we_low, ras_sff, cas_sff, col_we_low, is_read, uses_col;
  logic       in_ras_ph, in_col_ph, cmd_go, ser_go, ref_start, ref_tick;
  logic       ras_n_nxt, cas_n_nxt, we_n_nxt, dt_n_nxt, sff_nxt, pe_n_nxt, ad_oe_nxt;
  logic [8:0] addr_nxt;
  logic [3:0] ad_nxt;
  serial_if   sif();

  serial_engine u_serial (
    .clk_in                  (clk_in),
    .rstn_in                 (rstn_in),
    .sif                     (sif),
    .serial_clock_out        (serial_clock_out),
    .serial_data_pins_in     (serial_data_pins_in),
    .serial_data_pins_out    (serial_data_pins_out),
    .serial_data_pins_oe_out (serial_data_pins_oe_out)
  );

  // ***************************************************
  // cycle type decode
  // ***************************************************
  always_comb begin
    is_xfer    = op_r inside {OP_RD_XFER, OP_SPLIT_RD, OP_WR_XFER, OP_SPLIT_WR, OP_PSEUDO};
    ras_we_low = op_r inside {OP_MASK_WRITE, OP_MASK_BLOCK, OP_FLASH, OP_WR_XFER,
                              OP_SPLIT_WR, OP_PSEUDO};
    ras_sff    = op_r inside {OP_FLASH, OP_COLOR_WR, OP_COLOR_RD, OP_SPLIT_RD, OP_SPLIT_WR};
    cas_sff    = op_r inside {OP_BLOCK, OP_MASK_BLOCK};
    col_we_low = op_r inside {OP_WRITE, OP_MASK_WRITE, OP_BLOCK, OP_MASK_BLOCK, OP_COLOR_WR};
    is_read    = op_r inside {OP_READ, OP_COLOR_RD};
    uses_col   = !(op_r inside {OP_FLASH, OP_REFRESH});
  end

  assign in_ras_ph = (state_r == ST_SETUP) || (state_r == ST_RAS);
  assign in_col_ph = (state_r == ST_COL) || (state_r == ST_CAS);
  assign ref_start = (state_r == ST_IDLE) && ref_pend_r;
  assign cmd_go    = wr_in && (addr_in == `REG_CMD) && (state_r == ST_IDLE) && !ref_pend_r
                     && (wdata_in[3:0] <= OP_REFRESH);
  assign ser_go    = wr_in && (addr_in == `REG_SERIAL) && !sif.busy && started_r; // RULE24
  assign sif.start       = ser_go;
  assign sif.write       = host_drv_r;
  assign sif.wdata       = wdata_in[3:0];
  assign sif.host_drives = host_drv_r;

  // ***************************************************
  // pin levels per phase
  // ***************************************************
  always_comb begin
    ras_n_nxt = !(state_r inside {ST_RAS, ST_COL, ST_CAS, ST_DTUP});
    if (op_r == OP_REFRESH) begin
      cas_n_nxt = !(state_r inside {ST_SETUP, ST_RAS, ST_CAS}); // RULE5
    end else begin
      cas_n_nxt = !((state_r == ST_CAS) && uses_col);
    end
    if (is_xfer) begin
      dt_n_nxt = !(in_ras_ph || in_col_ph); // RULE6
    end else begin
      dt_n_nxt = !((state_r == ST_CAS) && is_read);
    end
    if (in_ras_ph || (is_xfer && in_col_ph)) begin
      we_n_nxt = !ras_we_low;
    end else begin
      we_n_nxt = !(in_col_ph && col_we_low);
    end
    if (in_ras_ph && op_r != OP_REFRESH) begin
      sff_nxt = ras_sff; // RULE8
    end else begin
      sff_nxt = in_col_ph && cas_sff; // RULE9
    end
    pe_n_nxt = ser_mask_r;
    if (in_ras_ph && op_r == OP_WR_XFER) begin
      pe_n_nxt = 1'b0;
    end else if (in_ras_ph && op_r == OP_PSEUDO) begin
      pe_n_nxt = 1'b1;
    end
    addr_nxt  = in_col_ph ? col_r : row_r;
    ad_nxt    = 4'h0;
    ad_oe_nxt = 1'b0;
    if (in_ras_ph && ras_we_low && !is_xfer) begin
      ad_nxt    = mask_r;
      ad_oe_nxt = 1'b1;
    end else if (in_col_ph && col_we_low) begin
      ad_nxt    = wdata_r;
      ad_oe_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ras_n_out                       <= 1'b1;
      cas_n_out                       <= 1'b1;
      we_n_out                        <= 1'b1;
      transfer_or_output_enable_n_out <= 1'b1;
      special_function_flag_out       <= 1'b0;
      serial_port_enable_n_out        <= 1'b0;
      addr_out                        <= 9'h000;
      array_data_pins_out             <= 4'h0;
      array_data_pins_oe_out          <= 1'b0;
    end else begin
      ras_n_out                       <= ras_n_nxt;
      cas_n_out                       <= cas_n_nxt;
      we_n_out                        <= we_n_nxt;
      transfer_or_output_enable_n_out <= dt_n_nxt;
      special_function_flag_out       <= sff_nxt;
      serial_port_enable_n_out        <= pe_n_nxt;
      addr_out                        <= addr_nxt;
      array_data_pins_out             <= ad_nxt;
      array_data_pins_oe_out          <= ad_oe_nxt;
    end
  end

  // ***************************************************
  // array cycle sequencer
  // ***************************************************
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_r <= ST_IDLE;
      op_r    <= OP_READ;
      hold_r  <= 2'h0;
    end else begin
      case (state_r)
        ST_IDLE: if (ref_start) begin
          op_r    <= OP_REFRESH;
          state_r <= ST_SETUP;
        end else if (cmd_go) begin
          op_r    <= op_t'(wdata_in[3:0]);
          state_r <= ST_SETUP;
        end
        ST_SETUP: state_r <= ST_RAS;
        ST_RAS: begin
          state_r <= uses_col ? ST_COL : ST_CAS;
          hold_r  <= `CAS_HOLD_CYC;
        end
        ST_COL: state_r <= ST_CAS;
        ST_CAS: if (hold_r == 2'h0) begin
          state_r <= ST_DTUP;
        end else begin
          hold_r <= hold_r - 2'h1;
        end
        ST_DTUP: state_r <= ST_PRE;
        ST_PRE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // read data sampled after the synchroniser has settled
  always_ff @(posedge clk_in) begin
    ad_s1_r   <= array_data_pins_in;
    ad_s2_r   <= ad_s1_r;
    half_s1_r <= split_half_flag_in;
    half_s2_r <= half_s1_r;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rdata_r <= 4'h0;
    end else if (state_r == ST_CAS && hold_r == 2'h0 && is_read) begin
      rdata_r <= ad_s2_r;
    end
  end

  // serial start position and pin direction track the last transfer
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      started_r  <= 1'b0;
      host_drv_r <= 1'b0;
    end else if (state_r == ST_PRE) begin
      if (op_r == OP_RD_XFER) begin
        started_r  <= 1'b1; // RULE24
        host_drv_r <= 1'b0;
      end else if (op_r == OP_PSEUDO) begin
        started_r  <= 1'b1;
        host_drv_r <= 1'b1;
      end else if (op_r == OP_WR_XFER) begin
        host_drv_r <= 1'b1;
      end
    end
  end

  // ***************************************************
  // refresh timer
  // ***************************************************
  assign ref_tick = (ref_cnt_r == 8'(`REF_INTERVAL_CYC - 1));

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ref_cnt_r  <= 8'h00;
      ref_pend_r <= 1'b0;
    end else begin
      ref_cnt_r <= ref_tick ? 8'h00 : ref_cnt_r + 8'h01;
      // a new tick wins over the clear of the one being served
      if (ref_tick && auto_ref_r) begin
        ref_pend_r <= 1'b1; // RULE4
      end else if (ref_start) begin
        ref_pend_r <= 1'b0;
      end
    end
  end

  // ***************************************************
  // register port
  // ***************************************************
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      row_r      <= 9'h000;
      col_r      <= 9'h000;
      wdata_r    <= 4'h0;
      mask_r     <= 4'hF;
      ser_mask_r <= 1'b0;
      auto_ref_r <= 1'b1;
    end else if (wr_in) begin
      case (addr_in)
        `REG_ROW:   row_r   <= wdata_in[8:0];
        `REG_COL:   col_r   <= wdata_in[8:0];
        `REG_WDATA: wdata_r <= wdata_in[3:0];
        `REG_MASK:  mask_r  <= wdata_in[3:0];
        `REG_CTRL: begin
          ser_mask_r <= wdata_in[`CTRL_SER_MASK];
          auto_ref_r <= wdata_in[`CTRL_AUTO_REF];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rdata_r2 <= 32'h0000_0000;
    end else if (rd_in) begin
      case (addr_in)
        `REG_CMD: begin
          rdata_r2                <= 32'h0000_0000;
          rdata_r2[`STAT_BUSY]     <= (state_r != ST_IDLE) || ref_pend_r;
          rdata_r2[`STAT_SER_BUSY] <= sif.busy;
          rdata_r2[`STAT_STARTED]  <= started_r;
          rdata_r2[`STAT_HOST_DRV] <= host_drv_r;
          rdata_r2[`STAT_HALF]     <= half_s2_r;
        end
        `REG_ROW:    rdata_r2 <= {23'h0, row_r};
        `REG_COL:    rdata_r2 <= {23'h0, col_r};
        `REG_WDATA:  rdata_r2 <= {28'h0, wdata_r};
        `REG_MASK:   rdata_r2 <= {28'h0, mask_r};
        `REG_RDATA:  rdata_r2 <= {28'h0, rdata_r};
        `REG_SERIAL: rdata_r2 <= {28'h0, sif.rdata};
        `REG_CTRL:   rdata_r2 <= {30'h0, auto_ref_r, ser_mask_r};
        default:     rdata_r2 <= 32'h0000_0000;
      endcase
    end else begin
      rdata_r2 <= 32'h0000_0000;
    end
  end
  assign rdata_out = rdata_r2;

  // ***************************************************
  // assertions
  // ***************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  AST_REF_SERVED: assert property (ref_pend_r |-> ##[1:16] !ref_pend_r) // RULE4
    else $error("refresh left pending too long");
  AST_REFRESH_ORDER: assert property ($fell(ras_n_out) && op_r == OP_REFRESH // RULE5
    |-> !cas_n_out && $past(!cas_n_out))
    else $error("refresh row strobe without column strobe first");
  AST_CAS_HIGH: assert property ($fell(ras_n_out) && op_r != OP_REFRESH |-> cas_n_out) // RULE5
    else $error("column strobe low at row strobe fall");
  AST_XFER_DT: assert property ($fell(ras_n_out) && op_r != OP_REFRESH // RULE6
    |-> transfer_or_output_enable_n_out == !is_xfer)
    else $error("transfer pin level wrong at row strobe fall");
  AST_DT_RISE: assert property ($rose(transfer_or_output_enable_n_out) && is_xfer // RULE6
    |-> !ras_n_out ##1 ras_n_out)
    else $error("transfer pin rose outside row cycle");
  AST_FLAG_RAS: assert property ($fell(ras_n_out) && op_r != OP_REFRESH // RULE8
    |-> special_function_flag_out == ras_sff)
    else $error("flag wrong at row strobe fall");
  AST_FLAG_CAS: assert property ($fell(cas_n_out) && !ras_n_out // RULE9
    |-> special_function_flag_out == cas_sff)
    else $error("flag wrong at column strobe fall");
  AST_SER_START: assert property ($rose(serial_clock_out) |-> started_r) // RULE24
    else $error("serial clock before start position set");

  COV_RD_XFER: cover property (state_r == ST_PRE && op_r == OP_RD_XFER);
  COV_REFRESH: cover property (ref_start);
  COV_BLOCK:   cover property ($fell(cas_n_out) && special_function_flag_out);
  COV_SERIAL:  cover property ($rose(serial_clock_out) && serial_data_pins_oe_out);
endmodule

// ---- sim/vram_dev_model.sv ----
// behavioural model of the dual-port video DRAM seen from its pins
module vram_dev_model (
  // array port
  input  wire logic       ras_n_in,
  input  wire logic       cas_n_in,
  input  wire logic       we_n_in,
  input  wire logic       dt_n_in,
  input  wire logic       sff_in,
  input  wire logic [8:0] a_in,
  input  wire logic [3:0] io_in,
  output logic [3:0]      io_out,
  output logic            io_oe_out,
  // serial port
  input  wire logic       pe_n_in,
  input  wire logic       ck_in,
  input  wire logic [3:0] sio_in,
  output logic [3:0]      sio_out,
  output logic            sio_oe_out,
  output logic            hlf_out
);
  // ***************************************************
  // storage and cycle decode
  // ***************************************************
  logic [3:0] mem [bit [17:0]];
  logic [3:0] sbf [512];
  logic [3:0] colr;
  logic [3:0] mask;
  logic [3:0] rdv;
  logic [8:0] row;
  logic [8:0] ptr;
  logic       xfer;
  logic       rfc;
  logic       we_r;
  logic       sff_r;
  logic       dir_out;
  int         n_ref;
  // unwritten cells read as zero so expectations stay simple
  function automatic logic [3:0] rm(logic [17:0] k);
    return mem.exists(k) ? mem[k] : 4'h0;
  endfunction
  function automatic logic [3:0] mix(logic [3:0] d, logic [17:0] k);
    return (d & mask) | (rm(k) & ~mask);
  endfunction
  initial begin
    n_ref = 0;
    dir_out = 1'b0;
    ptr = 9'h000;
    colr = 4'h0;
    rdv = 4'h0;
    rfc = 1'b1;
    hlf_out = 1'b0;
    sio_out = 4'h0;
  end
  always @(negedge ras_n_in) begin
    rfc = !cas_n_in;
    xfer = !dt_n_in;
    we_r = we_n_in;
    sff_r = sff_in;
    row = a_in;
    mask = we_n_in ? 4'hF : io_in;
    if (rfc) n_ref++;
    else if (xfer && !we_n_in) begin
      for (int i = 0; i < 512; i++)
        if (sff_in ? i[8] != ptr[8] : !pe_n_in) mem[{a_in, i[8:0]}] = sbf[i];
      if (!sff_in) dir_out = 1'b0;
    end else if (!xfer && sff_in && !we_n_in) begin
      for (int i = 0; i < 512; i++) mem[{a_in, i[8:0]}] = mix(colr, {a_in, i[8:0]});
    end
  end
  always @(posedge dt_n_in) begin
    if (!ras_n_in && xfer && !rfc && we_r) begin
      for (int i = 0; i < 512; i++)
        if (!sff_r || i[8] != ptr[8]) sbf[i] = rm({row, i[8:0]});
      if (!sff_r) dir_out = 1'b1;
    end
  end
  always @(negedge cas_n_in) begin
    if (!ras_n_in && !rfc) begin
      rdv = sff_r ? colr : rm({row, a_in});
      if (xfer) begin
        if (!sff_r) ptr = a_in;
      end else if (sff_r) begin
        if (!we_n_in) colr = io_in;
      end else if (sff_in) begin
        for (int i = 0; i < 4; i++)
          if (io_in[i]) mem[{row, a_in[8:2], i[1:0]}] = mix(colr, {row, a_in[8:2], i[1:0]});
      end else if (!we_n_in) mem[{row, a_in}] = mix(io_in, {row, a_in});
    end
  end
  assign io_oe_out = !ras_n_in && !cas_n_in && we_n_in && !dt_n_in && !xfer && !rfc;
  assign io_out = rdv;
  assign sio_oe_out = dir_out && !pe_n_in;
  always @(posedge ck_in) begin
    if (dir_out) sio_out <= sbf[ptr];
    else if (!pe_n_in) sbf[ptr] = sio_in;
    ptr = ptr + 9'h001;
    hlf_out <= ptr[8];
  end
endmodule

// ---- sim/vram_host_tb_top.sv ----
// self-checking bench: host controller against the video DRAM model
`include "vram_host_map.svh"
module vram_host_tb_top import vram_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [4:0] k;
    logic [8:0] r;
    logic [8:0] c;
    logic [3:0] w;
    logic [3:0] m;
    logic [7:0] ra;
    logic [7:0] ex;
  } row_t;
  localparam logic [4:0] ser_step = 5'h0E;
  localparam logic [4:0] ctl_wr = 5'h0F;
  // ***************************************************
  // cases: command, row, column, data, mask, read-back address, expected
  // ***************************************************
  row_t rows [28] = '{
    '{OP_WRITE, 9'h005, 9'h009, 4'hA, 4'hF, 8'hFF, 8'h00},
    '{OP_READ, 9'h005, 9'h009, 4'h0, 4'hF, 8'h14, 8'h0A},
    '{OP_MASK_WRITE, 9'h005, 9'h009, 4'h5, 4'h3, 8'hFF, 8'h00},
    '{OP_READ, 9'h005, 9'h009, 4'h0, 4'hF, 8'h14, 8'h09},
    '{OP_COLOR_WR, 9'h000, 9'h000, 4'h6, 4'hF, 8'hFF, 8'h00},
    '{OP_COLOR_RD, 9'h000, 9'h000, 4'h0, 4'hF, 8'h14, 8'h06},
    '{OP_BLOCK, 9'h007, 9'h010, 4'h5, 4'hF, 8'hFF, 8'h00},
    '{OP_READ, 9'h007, 9'h012, 4'h0, 4'hF, 8'h14, 8'h06},
    '{OP_READ, 9'h007, 9'h011, 4'h0, 4'hF, 8'h14, 8'h00},
    '{OP_MASK_BLOCK, 9'h007, 9'h010, 4'h2, 4'h4, 8'hFF, 8'h00},
    '{OP_READ, 9'h007, 9'h011, 4'h0, 4'hF, 8'h14, 8'h04},
    '{OP_FLASH, 9'h009, 9'h000, 4'h0, 4'hF, 8'hFF, 8'h00},
    '{OP_READ, 9'h009, 9'h1FF, 4'h0, 4'hF, 8'h14, 8'h06},
    '{OP_RD_XFER, 9'h009, 9'h0FE, 4'h0, 4'hF, 8'h00, 8'h04},
    '{ser_step, 9'h000, 9'h000, 4'h0, 4'hF, 8'h18, 8'h06},
    '{ser_step, 9'h000, 9'h000, 4'h0, 4'hF, 8'h00, 8'h14},
    '{OP_SPLIT_RD, 9'h009, 9'h000, 4'h0, 4'hF, 8'h00, 8'h14},
    '{ser_step, 9'h000, 9'h000, 4'h0, 4'hF, 8'h18, 8'h06},
    '{OP_PSEUDO, 9'h000, 9'h000, 4'h0, 4'hF, 8'h00, 8'h1C},
    '{ser_step, 9'h000, 9'h000, 4'h3, 4'hF, 8'h00, 8'h0C},
    '{ctl_wr, 9'h000, 9'h000, 4'h3, 4'hF, 8'hFF, 8'h00},
    '{ser_step, 9'h000, 9'h000, 4'h5, 4'hF, 8'hFF, 8'h00},
    '{ctl_wr, 9'h000, 9'h000, 4'h2, 4'hF, 8'hFF, 8'h00},
    '{OP_WR_XFER, 9'h00B, 9'h000, 4'h0, 4'hF, 8'hFF, 8'h00},
    '{OP_READ, 9'h00B, 9'h000, 4'h0, 4'hF, 8'h14, 8'h03},
    '{OP_READ, 9'h00B, 9'h001, 4'h0, 4'hF, 8'h14, 8'h06},
    '{OP_SPLIT_WR, 9'h00C, 9'h000, 4'h0, 4'hF, 8'h00, 8'h0C},
    '{OP_REFRESH, 9'h000, 9'h000, 4'h0, 4'hF, 8'h00, 8'h0C}
  };
  logic        clk_in;
  logic        rstn_in;
  logic        wr_in;
  logic        rd_in;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in;
  logic [31:0] rdata_out;
  logic        ras_n, cas_n, we_n, dt_n, sff, pe_n, ck, hoe, moe, soe, msoe, hlf, seen;
  logic [8:0]  a;
  logic [3:0]  hio, mio, io, io_last, hsio, msio, sio, sio_last;
  logic [31:0] d;
  int          n_mismatch;
  int          cmp_count;
  int          n_cyc;
  time         t0;
  // released lines show the inverse of their last level, never a kind default
  assign io = hoe ? hio : moe ? mio : ~io_last;
  assign sio = soe ? hsio : msoe ? msio : ~sio_last;
  always @(posedge clk_in) begin
    if (hoe || moe) io_last <= io;
    if (soe || msoe) sio_last <= sio;
  end
  always @(negedge ras_n) if (cas_n) n_cyc++;
  vram_host dut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ras_n_out(ras_n), .cas_n_out(cas_n),
    .we_n_out(we_n), .transfer_or_output_enable_n_out(dt_n), .special_function_flag_out(sff),
    .addr_out(a), .array_data_pins_in(io), .array_data_pins_out(hio),
    .array_data_pins_oe_out(hoe), .serial_port_enable_n_out(pe_n), .serial_clock_out(ck),
    .serial_data_pins_in(sio), .serial_data_pins_out(hsio), .serial_data_pins_oe_out(soe),
    .split_half_flag_in(hlf));
  vram_dev_model dev (.ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .dt_n_in(dt_n),
    .sff_in(sff), .a_in(a), .io_in(io), .io_out(mio), .io_oe_out(moe), .pe_n_in(pe_n),
    .ck_in(ck), .sio_in(sio), .sio_out(msio), .sio_oe_out(msoe), .hlf_out(hlf));
  // ***************************************************
  // register bus and checking tasks
  // ***************************************************
  task automatic wr(logic [7:0] ad, logic [31:0] v);
    @(posedge clk_in);
    addr_in <= ad;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(logic [7:0] ad, output logic [31:0] v);
    @(posedge clk_in);
    addr_in <= ad;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      n_mismatch++;
    end
  endtask
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // polls a status bit until clear; a stuck bit ends the run
  task automatic wait_idle(int b);
    logic [31:0] s;
    for (int i = 0; i < 300; i++) begin
      rd(`REG_CMD, s);
      if (!s[b]) return;
    end
    n_mismatch++;
    final_report();
  endtask
  task automatic do_row(row_t x);
    logic [31:0] v;
    int n;
    if (x.k == ser_step) begin
      wr(`REG_SERIAL, 32'(x.w));
      wait_idle(`STAT_SER_BUSY);
    end else if (x.k == ctl_wr) wr(`REG_CTRL, 32'(x.w));
    else begin
      wr(`REG_ROW, 32'(x.r));
      wr(`REG_COL, 32'(x.c));
      wr(`REG_WDATA, 32'(x.w));
      wr(`REG_MASK, 32'(x.m));
      // a pending refresh drops a command, so retry
      for (int i = 0; i < 4; i++) begin
        n = n_cyc;
        wr(`REG_CMD, 32'(x.k));
        wait_idle(`STAT_BUSY);
        if (n_cyc != n || x.k == OP_REFRESH) break;
      end
    end
    if (x.ra != 8'hFF) begin
      rd(x.ra, v);
      chk($sformatf("op %0d reg %h", x.k, x.ra), 32'(x.ex), v);
    end
  endtask
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    {rstn_in, wr_in, rd_in, addr_in, wdata_in, io_last, sio_last} = '0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    t0 = $time;
    foreach (rows[i]) do_row(rows[i]);
    // a command issued while busy must be dropped
    wr(`REG_WDATA, 32'h0);
    wr(`REG_CMD, 32'(OP_READ));
    wr(`REG_CMD, 32'(OP_WRITE));
    wait_idle(`STAT_BUSY);
    do_row('{OP_READ, 9'h005, 9'h009, 4'h0, 4'hF, 8'h14, 8'h09});
    rd(8'hF0, d);
    chk("unmapped read", 32'h0, d);
    chk("refresh count", 32'h1, 32'(dev.n_ref >= int'(($time - t0) / 15625) - 2));
    rstn_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    chk("row strobe idle", 32'h1, 32'(ras_n));
    rstn_in <= 1'b1;
    rd(`REG_CTRL, d);
    chk("ctrl reset", 32'h2, d);
    rd(`REG_MASK, d);
    chk("mask reset", 32'hF, d);
    rd(`REG_CMD, d);
    chk("status reset", 32'h0, d & 32'h7);
    wr(`REG_SERIAL, 32'h0);
    seen = 1'b0;
    repeat (8) begin
      @(posedge clk_in);
      seen = seen | ck;
    end
    chk("serial clock before start", 32'h0, 32'(seen));
    final_report();
  end
endmodule
